/* File: rbo_core.sv */
// Remote terminal build-option logic with APB status and interrupt registers
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (RULE1) Broadcast option on: address 31 is broadcast
// (RULE2) Broadcast option off: address 31 is ordinary
// (RULE3) Option off, own address 31: answer normally
// (RULE4) Echo off: separate subaddress 30 buffers
// (RULE5) Echo on: subaddress 30 transmit reads receive
// (RULE6) Backend port async when selected, else sync
// (RULE7) Bad-message option on: interrupt every message
// (RULE8) Bad-message option off: interrupt good only
// (RULE9) Overrun force honoured only with test option
// (RULE10) Init off: first last-status reply undefined
// (RULE11) Init on: first reply holds own address
// (RULE12) System asserts power-up reset for init
// (RULE13) Last-status init option defaults to zero
// (RULE14) Self-test option off: internal word returned
// (RULE15) Self-test option on: external input returned
// (RULE16) Self-test option defaults to internal word
// (RULE17) Bad parity or broadcast at 31: fault, ignore
// (RULE18) Broadcast messages get no status reply
module rbo_core
    import rbo_pkg::*;
#(
    parameter bit BROADCAST_SUPPORT_OPTION = 1'b1,
    parameter bit SUBADDR_THIRTY_ECHO_OPTION = 1'b0,
    parameter bit BACKEND_PORT_ASYNC_SELECT = 1'b0,
    parameter bit BAD_MESSAGE_IRQ_OPTION = 1'b0,
    parameter bit TX_OVERRUN_TEST_OPTION = 1'b0,
    parameter bit LAST_STATUS_INIT_OPTION = 1'b0, // RULE13
    parameter bit OUTSIDE_SELFTEST_SELECT = 1'b0 // RULE16
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Pins from outside the clock domain
    input wire logic [4:0] i_terminal_address_input,
    input wire logic i_addr_parity,
    input wire logic i_power_up_reset_n,
    input wire logic i_be_ack,
    // Protocol engine events
    input wire rbo_pkg::rbo_cmd_type i_cmd,
    input wire rbo_pkg::rbo_be_req_type i_be_req,
    input wire rbo_pkg::rbo_msg_done_type i_msg_done,
    input wire logic i_status_sent,
    input wire logic [15:0] i_status_word,
    input wire logic i_tx_timer_overrun,
    input wire logic i_tx_overrun_force_input,
    input wire logic [15:0] i_selftest_word_input,
    // Command results
    output logic o_terminal_address_fault,
    output logic o_cmd_accept,
    output logic o_cmd_broadcast,
    output logic o_reply_enable,
    output logic o_tx_word_valid,
    output logic [15:0] o_tx_word,
    output logic o_tx_overrun,
    output logic o_msg_event,
    // Backend memory port
    output logic [10:0] o_be_addr,
    output logic o_be_req,
    output logic o_be_async,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Interrupt
    output logic o_irq
);
    import rbo_pkg::*;

    logic [RBO_PIN_W-1:0] pins_stable; // Filtered pins
    logic [4:0] own_addr; // Filtered terminal address
    logic fault_reg; // Address fault
    logic accept_reg; // Command accepted pulse
    logic bcast_reg; // Accepted command is broadcast
    logic reply_reg; // Status reply allowed
    logic tx_valid_reg; // Transmit word valid pulse
    logic [15:0] tx_word_reg; // Transmit word
    logic overrun_reg; // Overrun pulse
    logic msg_event_reg; // Message interrupt event pulse
    logic [10:0] be_addr_reg; // Backend address
    logic be_req_reg; // Backend request
    logic [15:0] last_status_reg; // Last status word sent
    logic init_pending_reg; // Power-up reset seen, load pending
    logic [15:0] selftest_reg; // Internal self-test word
    logic fault_prev_reg; // Fault delayed for edge detect
    logic [RBO_IRQ_W-1:0] irq_status_reg; // Sticky events
    logic [RBO_IRQ_W-1:0] irq_status_next; // Next sticky events
    logic [RBO_IRQ_W-1:0] irq_enable_reg; // Interrupt enables
    logic [RBO_IRQ_W-1:0] irq_set; // Events this cycle
    logic [RBO_IRQ_W-1:0] irq_clr; // Clears this cycle
    logic [31:0] prdata_reg; // Read data
    logic [31:0] rd_mux; // Read data select
    logic addr_parity_ok; // Odd parity over address and parity pin
    logic fault_now; // Fault condition from filtered pins
    logic cmd_own; // Command addressed to this terminal
    logic cmd_bc; // Command is an accepted broadcast
    logic is_mode; // Command is a mode code
    logic ovr_now; // Overrun this cycle
    logic msg_irq_now; // Message counts for interrupt
    logic apb_wr; // APB write access
    logic mapped; // Address decodes to a register

    // Pin filtering
    rbo_sync #(
        .W(RBO_PIN_W)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_pins({i_be_ack, i_power_up_reset_n, i_addr_parity, i_terminal_address_input}),
        .o_stable(pins_stable)
    );
    assign own_addr = pins_stable[4:0];

    // Address fault condition
    always_comb begin
        addr_parity_ok = ^pins_stable[RBO_PIN_PAR:0];
        fault_now = !addr_parity_ok; // RULE17
        if (BROADCAST_SUPPORT_OPTION && own_addr == RBO_BCAST_ADDR) begin
            fault_now = 1'b1; // RULE17
        end
    end

    // Fault register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fault_reg <= 1'b0;
            fault_prev_reg <= 1'b0;
        end else begin
            fault_reg <= fault_now;
            fault_prev_reg <= fault_reg;
        end
    end

    // Command address match
    always_comb begin
        cmd_bc = BROADCAST_SUPPORT_OPTION && i_cmd.rt_addr == RBO_BCAST_ADDR; // RULE1
        cmd_own = i_cmd.rt_addr == own_addr && !cmd_bc; // RULE2 RULE3
        is_mode = i_cmd.subaddr == RBO_MC_SA_LO || i_cmd.subaddr == RBO_MC_SA_HI;
    end

    // Acceptance, broadcast flag and reply gate; faulted terminal ignores all
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            accept_reg <= 1'b0;
            bcast_reg <= 1'b0;
            reply_reg <= 1'b0;
        end else begin
            accept_reg <= i_cmd.valid && !fault_reg && (cmd_own || cmd_bc); // RULE17
            bcast_reg <= i_cmd.valid && !fault_reg && cmd_bc; // RULE1
            reply_reg <= i_cmd.valid && !fault_reg && cmd_own; // RULE18
        end
    end

    // Transmit word for status and self-test mode codes
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_valid_reg <= 1'b0;
            tx_word_reg <= 16'h0000;
        end else begin
            tx_valid_reg <= 1'b0;
            if (i_cmd.valid && !fault_reg && cmd_own && i_cmd.tr && is_mode) begin
                if (i_cmd.count == RBO_MC_TX_SELFTEST) begin
                    tx_valid_reg <= 1'b1;
                    // Selected source at build time
                    if (OUTSIDE_SELFTEST_SELECT) begin
                        tx_word_reg <= i_selftest_word_input; // RULE15
                    end else begin
                        tx_word_reg <= selftest_reg; // RULE14
                    end
                end else if (i_cmd.count == RBO_MC_TX_STATUS) begin
                    tx_valid_reg <= 1'b1;
                    tx_word_reg <= last_status_reg; // RULE10 RULE11
                end
            end
        end
    end

    // Last status word and its power-up initialisation
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last_status_reg <= RBO_LAST_STATUS_RST;
            init_pending_reg <= 1'b0;
        end else begin
            if (!pins_stable[RBO_PIN_PUR]) begin
                init_pending_reg <= 1'b1; // RULE12
            end else if (init_pending_reg) begin
                init_pending_reg <= 1'b0;
            end
            if (i_status_sent) begin
                last_status_reg <= i_status_word;
            end else if (init_pending_reg && pins_stable[RBO_PIN_PUR]) begin
                // Without the option the word keeps no meaningful content
                if (LAST_STATUS_INIT_OPTION) begin
                    last_status_reg <= {own_addr, RBO_STATUS_LOW_ZERO}; // RULE11
                end
            end
        end
    end

    // Overrun with gated test force
    assign ovr_now = i_tx_timer_overrun || (TX_OVERRUN_TEST_OPTION && i_tx_overrun_force_input); // RULE9

    // Internal self-test word and overrun pulse
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            selftest_reg <= RBO_ST_RST;
            overrun_reg <= 1'b0;
        end else begin
            overrun_reg <= ovr_now;
            if (ovr_now) begin
                selftest_reg[RBO_ST_OVERRUN] <= 1'b1;
            end
            if (fault_reg) begin
                selftest_reg[RBO_ST_FAULT] <= 1'b1;
            end
        end
    end

    // Message completion filter
    assign msg_irq_now = i_msg_done.valid && (!i_msg_done.err || BAD_MESSAGE_IRQ_OPTION); // RULE7 RULE8

    // Message event pulse
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            msg_event_reg <= 1'b0;
        end else begin
            msg_event_reg <= msg_irq_now; // RULE7 RULE8
        end
    end

    // Backend address with subaddress 30 echo mapping
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            be_addr_reg <= 11'h000;
        end else if (i_be_req.valid) begin
            be_addr_reg <= {i_be_req.tr, i_be_req.subaddr, i_be_req.word_idx}; // RULE4
            if (SUBADDR_THIRTY_ECHO_OPTION && i_be_req.subaddr == RBO_ECHO_SA) begin
                be_addr_reg[RBO_BE_DIR_BIT] <= 1'b0; // RULE5
            end
        end
    end

    // Backend request: one cycle in sync mode, held to ack in async mode
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            be_req_reg <= 1'b0;
        end else if (BACKEND_PORT_ASYNC_SELECT) begin
            if (i_be_req.valid) begin
                be_req_reg <= 1'b1; // RULE6
            end else if (pins_stable[RBO_PIN_ACK]) begin
                be_req_reg <= 1'b0; // RULE6
            end
        end else begin
            be_req_reg <= i_be_req.valid; // RULE6
        end
    end

    // Interrupt sources; set wins over clear
    always_comb begin
        irq_set = '0;
        irq_set[RBO_IRQ_GOOD] = i_msg_done.valid && !i_msg_done.err;
        irq_set[RBO_IRQ_BAD] = msg_irq_now && i_msg_done.err; // RULE7 RULE8
        irq_set[RBO_IRQ_OVERRUN] = ovr_now;
        irq_set[RBO_IRQ_ADDR_FAULT] = fault_reg && !fault_prev_reg;
        irq_clr = '0;
        if (apb_wr && i_paddr == RBO_IRQ_CLEAR_OFS) begin
            irq_clr = i_pwdata[RBO_IRQ_W-1:0];
        end
        irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
    end

    // Sticky status and enable registers
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_status_reg <= RBO_IRQ_RST;
            irq_enable_reg <= RBO_IRQ_RST;
        end else begin
            irq_status_reg <= irq_status_next;
            if (apb_wr && i_paddr == RBO_IRQ_ENABLE_OFS) begin
                irq_enable_reg <= i_pwdata[RBO_IRQ_W-1:0];
            end
        end
    end

    // APB decode
    assign apb_wr = i_psel && i_penable && i_pwrite;
    assign mapped = i_paddr == RBO_IRQ_STATUS_OFS || i_paddr == RBO_IRQ_CLEAR_OFS ||
                    i_paddr == RBO_IRQ_ENABLE_OFS || i_paddr == RBO_OPTIONS_OFS ||
                    i_paddr == RBO_LAST_STATUS_OFS;

    // Read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (i_paddr)
            RBO_IRQ_STATUS_OFS: begin
                rd_mux[RBO_IRQ_W-1:0] = irq_status_reg;
            end
            RBO_IRQ_ENABLE_OFS: begin
                rd_mux[RBO_IRQ_W-1:0] = irq_enable_reg;
            end
            RBO_OPTIONS_OFS: begin
                rd_mux[RBO_OPT_BCAST] = BROADCAST_SUPPORT_OPTION;
                rd_mux[RBO_OPT_ECHO] = SUBADDR_THIRTY_ECHO_OPTION;
                rd_mux[RBO_OPT_ASYNC] = BACKEND_PORT_ASYNC_SELECT;
                rd_mux[RBO_OPT_BADIRQ] = BAD_MESSAGE_IRQ_OPTION;
                rd_mux[RBO_OPT_OVRTEST] = TX_OVERRUN_TEST_OPTION;
                rd_mux[RBO_OPT_LSINIT] = LAST_STATUS_INIT_OPTION;
                rd_mux[RBO_OPT_EXTST] = OUTSIDE_SELFTEST_SELECT;
                rd_mux[RBO_OPT_FAULT] = fault_reg;
            end
            RBO_LAST_STATUS_OFS: begin
                rd_mux[15:0] = last_status_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured in the setup phase
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prdata_reg <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            prdata_reg <= rd_mux;
        end
    end

    // Outputs
    assign o_terminal_address_fault = fault_reg;
    assign o_cmd_accept = accept_reg;
    assign o_cmd_broadcast = bcast_reg;
    assign o_reply_enable = reply_reg;
    assign o_tx_word_valid = tx_valid_reg;
    assign o_tx_word = tx_word_reg;
    assign o_tx_overrun = overrun_reg;
    assign o_msg_event = msg_event_reg;
    assign o_be_addr = be_addr_reg;
    assign o_be_req = be_req_reg;
    assign o_be_async = BACKEND_PORT_ASYNC_SELECT; // RULE6
    assign o_prdata = prdata_reg;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;
    assign o_irq = |(irq_status_reg & irq_enable_reg);

    // Checks
    sequence own_selftest_cmd_s;
        i_cmd.valid && !fault_reg && cmd_own && i_cmd.tr && is_mode &&
        i_cmd.count == RBO_MC_TX_SELFTEST;
    endsequence
    sequence bad_msg_s;
        i_msg_done.valid && i_msg_done.err;
    endsequence

    parity_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE17
        i_rst_b && !addr_parity_ok |=> o_terminal_address_fault)
        else $error("parity fault not flagged");
    bcast_fault_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE17
        i_rst_b && BROADCAST_SUPPORT_OPTION && own_addr == RBO_BCAST_ADDR
        |=> o_terminal_address_fault)
        else $error("broadcast address fault not flagged");
    fault_ignore_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE17
        o_terminal_address_fault |=> !o_cmd_accept)
        else $error("command accepted during fault");
    own_accept_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE3
        i_cmd.valid && !fault_reg && i_cmd.rt_addr == own_addr |=> o_cmd_accept)
        else $error("own command not accepted");
    bcast_noreply_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE18
        o_cmd_broadcast |-> o_cmd_accept && !o_reply_enable)
        else $error("broadcast replied");
    echo_map_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE5
        SUBADDR_THIRTY_ECHO_OPTION && i_be_req.valid && i_be_req.subaddr == RBO_ECHO_SA
        |=> !o_be_addr[RBO_BE_DIR_BIT])
        else $error("echo mapping not applied");
    split_buf_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE4
        !SUBADDR_THIRTY_ECHO_OPTION && i_be_req.valid
        |=> o_be_addr[RBO_BE_DIR_BIT] == $past(i_be_req.tr))
        else $error("direction bit altered");
    good_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE7
        i_msg_done.valid && !i_msg_done.err |=> o_msg_event ##0 irq_status_reg[RBO_IRQ_GOOD])
        else $error("good message event lost");
    bad_irq_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE8
        bad_msg_s |=> o_msg_event == BAD_MESSAGE_IRQ_OPTION)
        else $error("bad message event mis-gated");
    overrun_gate_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE9
        !TX_OVERRUN_TEST_OPTION && !i_tx_timer_overrun |=> !o_tx_overrun)
        else $error("overrun force not gated");
    selftest_src_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // RULE14
        own_selftest_cmd_s |=> o_tx_word_valid && o_tx_word == (OUTSIDE_SELFTEST_SELECT ?
        $past(i_selftest_word_input) : $past(selftest_reg)))
        else $error("self-test word source wrong");
endmodule
`default_nettype wire

/* File: rbo_pkg.sv */
// Shared constants and carrier types for the terminal build-option block
package rbo_pkg;
    // Terminal address and mode code values
    localparam logic [4:0] RBO_BCAST_ADDR = 5'h1F;
    localparam logic [4:0] RBO_ECHO_SA = 5'h1E;
    localparam logic [4:0] RBO_MC_SA_LO = 5'h00;
    localparam logic [4:0] RBO_MC_SA_HI = 5'h1F;
    localparam logic [4:0] RBO_MC_TX_STATUS = 5'h02;
    localparam logic [4:0] RBO_MC_TX_SELFTEST = 5'h13;
    // Backend address layout: direction bit above subaddress and word index
    localparam int RBO_BE_AW = 11;
    localparam int RBO_BE_DIR_BIT = 10;
    // Status word layout: terminal address in the top five bits
    localparam logic [10:0] RBO_STATUS_LOW_ZERO = 11'h000;
    localparam logic [15:0] RBO_LAST_STATUS_RST = 16'h0000;
    // APB register byte offsets
    localparam logic [7:0] RBO_IRQ_STATUS_OFS = 8'h00;
    localparam logic [7:0] RBO_IRQ_CLEAR_OFS = 8'h04;
    localparam logic [7:0] RBO_IRQ_ENABLE_OFS = 8'h08;
    localparam logic [7:0] RBO_OPTIONS_OFS = 8'h0C;
    localparam logic [7:0] RBO_LAST_STATUS_OFS = 8'h10;
    // Interrupt bit positions
    localparam int RBO_IRQ_W = 4;
    localparam int RBO_IRQ_GOOD = 0;
    localparam int RBO_IRQ_BAD = 1;
    localparam int RBO_IRQ_OVERRUN = 2;
    localparam int RBO_IRQ_ADDR_FAULT = 3;
    localparam logic [RBO_IRQ_W-1:0] RBO_IRQ_RST = 4'h0;
    // Option readback field positions
    localparam int RBO_OPT_BCAST = 0;
    localparam int RBO_OPT_ECHO = 1;
    localparam int RBO_OPT_ASYNC = 2;
    localparam int RBO_OPT_BADIRQ = 3;
    localparam int RBO_OPT_OVRTEST = 4;
    localparam int RBO_OPT_LSINIT = 5;
    localparam int RBO_OPT_EXTST = 6;
    localparam int RBO_OPT_FAULT = 8;
    // Internal self-test word fields
    localparam int RBO_ST_OVERRUN = 15;
    localparam int RBO_ST_FAULT = 14;
    localparam logic [15:0] RBO_ST_RST = 16'h0000;
    // Pin synchroniser layout: address, parity, power-up reset, backend ack
    localparam int RBO_PIN_W = 8;
    localparam int RBO_PIN_PAR = 5;
    localparam int RBO_PIN_PUR = 6;
    localparam int RBO_PIN_ACK = 7;

    // Command word as decoded by the protocol engine
    typedef struct packed {
        logic valid;
        logic [4:0] rt_addr;
        logic tr;
        logic [4:0] subaddr;
        logic [4:0] count;
    } rbo_cmd_type;

    // Backend buffer access request from the protocol engine
    typedef struct packed {
        logic valid;
        logic tr;
        logic [4:0] subaddr;
        logic [4:0] word_idx;
    } rbo_be_req_type;

    // End-of-message report
    typedef struct packed {
        logic valid;
        logic err;
    } rbo_msg_done_type;
endpackage

/* File: rbo_sync.sv */
// Three-stage pin synchroniser with agreement filter per bit
`timescale 1ns/1ps
`default_nettype none
module rbo_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Pins and filtered result
    input wire logic [W-1:0] i_pins,
    output logic [W-1:0] o_stable
);
    // One filter per bit
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic s1_reg; // First stage, read only by second
            logic s2_reg; // Second stage
            logic s3_reg; // Third stage
            logic st_reg; // Accepted level
            // Shift chain
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end else begin
                    s1_reg <= i_pins[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            // Take a change once stages two and three agree
            always_ff @(posedge i_core_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    st_reg <= 1'b0;
                end else if (s2_reg == s3_reg) begin
                    st_reg <= s3_reg;
                end
            end
            assign o_stable[g] = st_reg;
        end
    endgenerate
endmodule
`default_nettype wire

/* File: rbo_bc_model.sv */
// Bus controller stand-in that issues command and end-of-message events
`timescale 1ns/1ps
`default_nettype none
module rbo_bc_model
    import rbo_pkg::*;
(
    // Clock
    input wire logic i_core_clk,
    // Events towards the terminal
    output var rbo_pkg::rbo_cmd_type o_cmd,
    output var rbo_pkg::rbo_msg_done_type o_msg_done,
    output var logic o_power_up_reset_n
);
    // Quiet bus, power-up reset held at power-up
    initial begin
        o_cmd = '0;
        o_msg_done = '0;
        o_power_up_reset_n = 1'b0;
    end
    // Release power-up reset once the core clock runs
    task power_up();
        @(posedge i_core_clk);
        o_power_up_reset_n <= 1'b1;
    endtask
    // One command word, a single-cycle pulse
    task send_cmd(input logic [4:0] a, input logic tr, input logic [4:0] sa, input logic [4:0] n);
        @(posedge i_core_clk);
        o_cmd <= '{1'b1, a, tr, sa, n};
        @(posedge i_core_clk);
        o_cmd <= '0;
    endtask
    // End of message, good or erroneous
    task end_msg(input logic e);
        @(posedge i_core_clk);
        o_msg_done <= '{1'b1, e};
        @(posedge i_core_clk);
        o_msg_done <= '0;
    endtask
endmodule
`default_nettype wire

/* File: rbo_core_tb.sv */
// Self-checking bench for the terminal build-option block
`timescale 1ns/1ps
`default_nettype none
module rbo_core_tb;
    import rbo_pkg::*;
    logic clk, rst_b, par, be_ack, sent, ovr, force_ovr, psel, pen, pwr;
    logic [4:0] addr, addr2;
    logic [15:0] sw, st_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, p2d;
    logic pready, pslverr, irq, fault, acc, bc, rep, txv, txo, ev, bereq, beasy, err;
    logic [15:0] txw, t2w;
    logic [10:0] beaddr, b2a;
    logic a2, r2, t2v, o2, e2, q2, i2;
    rbo_cmd_type cmd;
    rbo_msg_done_type done;
    rbo_be_req_type be;
    logic pur_b;
    int fail_count, comparisons;
    rbo_bc_model u_rbo_bc_model (.i_core_clk(clk), .o_cmd(cmd), .o_msg_done(done),
        .o_power_up_reset_n(pur_b));
    rbo_core u_rbo_core (.i_core_clk(clk), .i_rst_b(rst_b), .i_terminal_address_input(addr),
        .i_addr_parity(par), .i_power_up_reset_n(pur_b), .i_be_ack(be_ack), .i_cmd(cmd),
        .i_be_req(be), .i_msg_done(done), .i_status_sent(sent), .i_status_word(sw),
        .i_tx_timer_overrun(ovr), .i_tx_overrun_force_input(force_ovr),
        .i_selftest_word_input(st_in), .o_terminal_address_fault(fault), .o_cmd_accept(acc),
        .o_cmd_broadcast(bc), .o_reply_enable(rep), .o_tx_word_valid(txv), .o_tx_word(txw),
        .o_tx_overrun(txo), .o_msg_event(ev), .o_be_addr(beaddr), .o_be_req(bereq),
        .o_be_async(beasy), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_irq(irq));
    // Second build with every option flipped
    rbo_core #(.BROADCAST_SUPPORT_OPTION(1'b0), .SUBADDR_THIRTY_ECHO_OPTION(1'b1),
        .BACKEND_PORT_ASYNC_SELECT(1'b1), .BAD_MESSAGE_IRQ_OPTION(1'b1),
        .TX_OVERRUN_TEST_OPTION(1'b1), .LAST_STATUS_INIT_OPTION(1'b1),
        .OUTSIDE_SELFTEST_SELECT(1'b1)) u_rbo_core_alt (.i_core_clk(clk), .i_rst_b(rst_b),
        .i_terminal_address_input(addr2), .i_addr_parity(~^addr2), .i_power_up_reset_n(pur_b),
        .i_be_ack(be_ack), .i_cmd(cmd), .i_be_req(be), .i_msg_done(done), .i_status_sent(sent),
        .i_status_word(sw), .i_tx_timer_overrun(ovr), .i_tx_overrun_force_input(force_ovr),
        .i_selftest_word_input(st_in), .o_terminal_address_fault(), .o_cmd_accept(a2),
        .o_cmd_broadcast(), .o_reply_enable(r2), .o_tx_word_valid(t2v), .o_tx_word(t2w),
        .o_tx_overrun(o2), .o_msg_event(e2), .o_be_addr(b2a), .o_be_req(q2), .o_be_async(),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(p2d), .o_pready(), .o_pslverr(), .o_irq(i2));
    // Compare one value against its expectation
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite_set(w, a, d);
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Address, direction and data of a setup cycle
    task pwrite_set(input logic w, input logic [7:0] a, input logic [31:0] d);
        pwr <= w;
        paddr <= a;
        pwdata <= d;
    endtask
    // Counts, verdict and end of run
    task report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Core clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    // Test sequence
    initial begin
        {rst_b, be_ack, sent, ovr, force_ovr, psel, pen, pwr} = '0;
        {paddr, pwdata, sw, st_in, be} = '0;
        addr = 5'h05;
        addr2 = 5'h1F;
        st_in = 16'hA5C3;
        par = 1'b1;
        fail_count = 0;
        comparisons = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        u_rbo_bc_model.power_up();
        repeat (10) @(posedge clk);
        #1 check(fault, 1'b0);
        apb(1'b0, RBO_OPTIONS_OFS, 32'h0);
        check(rd, 32'h1);
        u_rbo_bc_model.send_cmd(5'h05, 1'b1, 5'h00, RBO_MC_TX_SELFTEST);
        #1 check({txv, txw}, {1'b1, 16'h4000});
        u_rbo_bc_model.send_cmd(5'h05, 1'b1, 5'h1F, RBO_MC_TX_STATUS);
        #1 check({txv, txw}, {1'b1, 16'h0000});
        u_rbo_bc_model.send_cmd(RBO_BCAST_ADDR, 1'b0, 5'h01, 5'h01);
        #1 check({acc, bc, rep}, 3'b110);
        check({a2, r2}, 2'b11);
        u_rbo_bc_model.send_cmd(RBO_BCAST_ADDR, 1'b1, 5'h00, RBO_MC_TX_STATUS);
        #1 check({t2v, t2w}, {1'b1, 16'hF800});
        u_rbo_bc_model.send_cmd(RBO_BCAST_ADDR, 1'b1, 5'h1F, RBO_MC_TX_SELFTEST);
        #1 check({t2v, t2w}, {1'b1, 16'hA5C3});
        u_rbo_bc_model.send_cmd(5'h06, 1'b0, 5'h01, 5'h01);
        #1 check({acc, bc, rep}, 3'b000);
        @(posedge clk);
        be <= '{1'b1, 1'b1, RBO_ECHO_SA, 5'h03};
        @(posedge clk);
        be <= '0;
        #1 check(beaddr, {1'b1, RBO_ECHO_SA, 5'h03});
        check({bereq, beasy}, 2'b10);
        check(b2a, {1'b0, RBO_ECHO_SA, 5'h03});
        @(posedge clk);
        #1 check({bereq, q2}, 2'b01);
        apb(1'b1, RBO_IRQ_ENABLE_OFS, 32'h3);
        u_rbo_bc_model.end_msg(1'b1);
        #1 check({ev, irq}, 2'b00);
        check({e2, i2}, 2'b11);
        u_rbo_bc_model.end_msg(1'b0);
        #1 check({ev, irq}, 2'b11);
        apb(1'b0, RBO_IRQ_STATUS_OFS, 32'h0);
        check(rd, 32'h9);
        check(p2d, 32'hB);
        apb(1'b1, RBO_IRQ_CLEAR_OFS, 32'h1);
        #1 check(irq, 1'b0);
        @(posedge clk);
        force_ovr <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check({txo, o2}, 2'b01);
        apb(1'b0, 8'h40, 32'h0);
        check({err, rd[30:0]}, {1'b1, 31'h0});
        addr <= RBO_BCAST_ADDR;
        par <= 1'b0;
        repeat (8) @(posedge clk);
        #1 check(fault, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
